// ==== rtl/spi_cfg_map.svh ====
// timing counts and frame field positions for the serial control master
`ifndef SPI_CFG_MAP_SVH
`define SPI_CFG_MAP_SVH
`define FRAME_BITS 24
`define DIR_BIT 23
`define MB_HI_BIT 22
`define MB_LO_BIT 21
`define ADDR_MSB 20
`define ADDR_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0
`define ADDR_BITS 13
`define DATA_BITS 8
`define HALF_PERIOD_NS 24
`define CLK_PERIOD_NS 4
`define HALF_CYCLES (`HALF_PERIOD_NS / `CLK_PERIOD_NS)
`define GAP_CYCLES 6
`endif

// ==== rtl/spi_cfg_master.sv ====
// serial control port master: one 24-bit frame per request
// Function
// - one 24-bit frame on three lines
// - dir, multibyte, 13-bit address, data byte
// - dir one reads register back
// - dir zero writes final byte
// - host drives multibyte bits zero
// - host shifts address msb first on falls
// - host releases line, samples read byte
// - host shifts write byte msb first
// - enable drop ends read, line released
// - enable drop after last edge ends write
`timescale 1ns/1ns
`include "spi_cfg_map.svh"
module spi_cfg_master #(
  parameter int HALF_CYCLES = `HALF_CYCLES,
  parameter int GAP_CYCLES = `GAP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire spi_cfg_pkg::cfg_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [7:0] rdata,
  output logic done,
  output spi_cfg_pkg::pin_out_t pins,
  input wire logic sd_in
);
  import spi_cfg_pkg::*;

  typedef enum logic [2:0] {IDLE, LEAD, LOW, HIGH, TAIL, GAP} state_t;

  state_t state_ff;
  logic [23:0] shift_ff;
  logic [4:0] bit_ff;
  logic rd_ff;
  logic [7:0] rx_ff;
  logic [7:0] gap_ff;
  logic sd_s1_ff;
  logic sd_s2_ff;
  logic tick;
  logic run;
  // helpers decoded from the state, read by the sequencer, the frame word load and the output registers
  // take: request accepted this edge; frame_end: end of the tail half period after the last fall
  logic take;
  logic frame_end;
  // rel_now: host lets go of the line for the returned read byte
  logic rel_now;
  // next pin levels, registered in the pin block
  logic nxt_en;
  logic nxt_sclk;
  logic nxt_sd_oe;

  // parameter ranges the sequencer can serve; below three mclk per half
  // period the two sync stages cannot settle before the read sample
  if (HALF_CYCLES < 3 || HALF_CYCLES > 65535) begin : g_bad_half
    $error("spi_cfg_master: HALF_CYCLES out of range");
  end
  if (GAP_CYCLES < 1 || GAP_CYCLES > 255) begin : g_bad_gap
    $error("spi_cfg_master: GAP_CYCLES out of range");
  end

  // divider runs only while a frame is open
  assign run = (state_ff != IDLE) && (state_ff != GAP);

  // only idle takes a request, so a valid held through the gap just waits
  assign take = (state_ff == IDLE) && req_valid;

  // the tick that ends the tail half period after the last fall closes the frame
  assign frame_end = (state_ff == TAIL) && tick;

  // read byte phase opens at the fall after the last address rise;
  // letting go at that same fall avoids both ends driving together
  assign rel_now = rd_ff &&
                   ((bit_ff >= 5'(`FRAME_BITS - `DATA_BITS)) ||
                    (state_ff == HIGH && tick &&
                     bit_ff == 5'(`FRAME_BITS - `DATA_BITS - 1)));

  // next pin levels; sclk is decoded one mclk ahead of the state change
  // so that the first high phase is as wide as all the others
  assign nxt_en = run && !frame_end;
  assign nxt_sclk = ((state_ff == LEAD || state_ff == LOW) && tick) ||
                    (state_ff == HIGH && !tick);
  // line released for the returned byte and at frame end
  assign nxt_sd_oe = run && !rel_now && !frame_end;

  tick_gen #(.HALF(HALF_CYCLES)) u_tick (
    .mclk(mclk),
    .rst(rst),
    .run(run),
    .tick(tick)
  );

  // two-stage sync of the returned data line
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sd_s1_ff <= 1'b0;
      sd_s2_ff <= 1'b0;
    end else begin
      sd_s1_ff <= sd_in;
      sd_s2_ff <= sd_s1_ff;
    end
  end

  // frame sequencer; each tick is one half period of the serial clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= IDLE;
      bit_ff <= 5'h00;
      gap_ff <= 8'h00;
    end else begin
      case (state_ff)
        IDLE: begin
          if (take) begin
            state_ff <= LEAD;
            bit_ff <= 5'h00;
          end
        end
        LEAD: if (tick) state_ff <= HIGH;
        HIGH: begin
          if (tick) begin
            if (bit_ff == 5'(`FRAME_BITS - 1)) begin
              state_ff <= TAIL;
            end else begin
              state_ff <= LOW;
              bit_ff <= bit_ff + 5'h01;
            end
          end
        end
        LOW: if (tick) state_ff <= HIGH;
        TAIL: begin
          if (tick) begin
            state_ff <= GAP;
            gap_ff <= 8'h00;
          end
        end
        GAP: begin
          // idle time with enable low before the next frame
          if (gap_ff == 8'(GAP_CYCLES - 1)) begin
            state_ff <= IDLE;
          end else begin
            gap_ff <= gap_ff + 8'h01;
          end
        end
        default: state_ff <= IDLE;
      endcase
    end
  end

  // frame word load and shifting on falling serial clock edges
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_ff <= 24'h000000;
      rd_ff <= 1'b0;
    end else if (take) begin
      // multibyte field forced to zero
      shift_ff <= {req.rd, 2'b00, req.addr, req.wdata};
      rd_ff <= req.rd;
    end else if (state_ff == HIGH && tick) begin
      shift_ff <= {shift_ff[22:0], 1'b0};
    end
  end

  // read byte captured at rising edges of the data phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_ff <= 8'h00;
    end else if (state_ff == LOW && tick && rd_ff &&
                 bit_ff > 5'(`FRAME_BITS - 1 - `DATA_BITS)) begin
      // sampled late in the low phase so the sync delay is covered
      rx_ff <= {rx_ff[6:0], sd_s2_ff};
    end
  end

  // completion pulse, one mclk wide, in the cycle the enable drops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= frame_end;
    end
  end

  // read result; all eight bits are in rx once the last rise has passed,
  // so no further sample is taken at frame end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (frame_end && rd_ff) begin
      rdata <= rx_ff;
    end
  end

  // advisory ready; low while valid is up so one request is not seen twice
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_ff == IDLE) && !req_valid;
    end
  end

  // pin drivers, all registered so the pads never see decode glitches;
  // the data bit changes one mclk after each fall, well clear of the rise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pins <= '0;
    end else begin
      pins.port_select_enable <= nxt_en;
      pins.sclk <= nxt_sclk;
      pins.sd_out <= shift_ff[`FRAME_BITS - 1];
      pins.sd_oe <= nxt_sd_oe;
    end
  end
endmodule : spi_cfg_master

// ==== rtl/spi_cfg_pkg.sv ====
// types shared by the serial control master
package spi_cfg_pkg;
  typedef struct packed {
    logic rd;
    logic [12:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;
  typedef struct packed {
    logic port_select_enable;
    logic sclk;
    logic sd_out;
    logic sd_oe;
  } pin_out_t;
endpackage : spi_cfg_pkg

// ==== rtl/tick_gen.sv ====
// half-period tick divider for the serial clock
`timescale 1ns/1ns
module tick_gen #(
  parameter int HALF = 6
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  logic [15:0] cnt_ff;

  initial begin
    if (HALF < 1 || HALF > 65535) begin
      $error("tick_gen: bad HALF");
    end
  end

  // counter restarts whenever the frame is idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_ff == 16'(HALF - 1)) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : tick_gen

// ==== tb/cfg_dev_model.sv ====
// behavioural configuration device on the far side of the serial port
`timescale 1ns/1ns
module cfg_dev_model (
  input wire logic en,
  input wire logic sclk,
  input wire logic line,
  output logic sd_q
);
  logic [7:0] mem [int];
  logic [23:0] frame;
  logic [7:0] rb;
  int n = 0;
  initial sd_q = 1'b0;
  // frame state cleared only by the enable; there is no reset pin
  always @(posedge sclk or negedge en) begin
    if (!en) begin
      n = 0;
      sd_q = ~sd_q;
    end else begin
      frame = {frame[22:0], line};
      n++;
      if (n == 16 && frame[15]) rb = mem[frame[12:0]];
      // commit only on the 24th rise of a write; cut frames are dropped
      if (n == 24 && !frame[23]) begin
        mem[frame[20:8]] = frame[7:0];
      end
    end
  end
  // read byte on falls; a released line shows the inverse of its last value
  always @(negedge sclk) begin
    if (en && n >= 16 && n < 24 && frame[n-1]) sd_q = rb[23-n];
    else sd_q = ~sd_q;
  end
endmodule : cfg_dev_model

// ==== tb/spi_cfg_master_asserts.sv ====
// pin-level assertions for the serial control master
`timescale 1ns/1ns
module spi_cfg_master_asserts #(
  parameter int HALF_CYCLES = 6
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic done,
  input wire spi_cfg_pkg::pin_out_t pins
);
  import spi_cfg_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // repetition counts are plain figures for the default half period
  a_idle_clk_low: assert property (
    !pins.port_select_enable |-> !pins.sclk)
    else $error("serial clock high outside a frame");
  a_half_high: assert property (
    $rose(pins.sclk) |-> pins.sclk[*6] ##1 !pins.sclk)
    else $error("serial clock high phase wrong length");
  a_half_low: assert property (
    $fell(pins.sclk) |-> !pins.sclk[*6])
    else $error("serial clock low phase too short");
  a_start_clk_low: assert property (
    $rose(pins.port_select_enable) |-> !pins.sclk)
    else $error("frame opened with clock high");
  a_stable_on_rise: assert property (
    pins.sd_oe && $rose(pins.sclk) |-> $stable(pins.sd_out))
    else $error("data changed at a rising clock");
  a_oe_in_frame: assert property (
    pins.sd_oe |-> pins.port_select_enable)
    else $error("data line driven outside a frame");
  a_done_once: assert property (
    done |=> !done)
    else $error("done longer than one cycle");
  a_busy_start: assert property (
    $fell(req_ready) |-> ##[0:2] pins.port_select_enable)
    else $error("taken request opened no frame");
  a_done_after_en: assert property (
    $fell(pins.port_select_enable) |-> ##[0:3] done)
    else $error("frame end gave no done");
endmodule : spi_cfg_master_asserts
bind spi_cfg_master spi_cfg_master_asserts #(.HALF_CYCLES(HALF_CYCLES)) u_chk (
  .mclk(mclk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
  .done(done), .pins(pins));

// ==== tb/tb_spi_cfg_master.sv ====
// self-checking bench for the serial control master
`timescale 1ns/1ns
`include "spi_cfg_map.svh"
module tb_spi_cfg_master;
  import spi_cfg_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  cfg_req_t req = '0;
  logic req_valid = 1'b0;
  logic req_ready, done, sd_q, line;
  logic [7:0] rdata;
  pin_out_t pins;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] ref_mem [int];
  logic [12:0] a;
  logic [7:0] d;
  int gap_seen = 0;
  always #2 mclk = ~mclk;
  // wire level: master while its sd_oe is up, device otherwise
  assign line = pins.sd_oe ? pins.sd_out : sd_q;
  spi_cfg_master dut (.mclk(mclk), .rst(rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata),
    .done(done), .pins(pins), .sd_in(line));
  cfg_dev_model dev (.en(pins.port_select_enable), .sclk(pins.sclk),
    .line(line), .sd_q(sd_q));
  task chk(input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task print_verdict;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // one frame; held until the enable shows it was taken
  task xfer(input logic rd);
    @(negedge mclk);
    req = '{rd, a, d};
    req_valid = 1'b1;
    do @(posedge mclk); while (pins.port_select_enable !== 1'b1);
    @(negedge mclk);
    req_valid = 1'b0;
    while (done !== 1'b1) @(negedge mclk);
    // enable, clock and drive all down while done stands
    chk({pins.port_select_enable, pins.sclk, pins.sd_oe}, 3'h0);
    chk(dev.frame[23:8], {rd, 2'b00, a});
    if (rd) chk(rdata, ref_mem[a]);
    else begin
      ref_mem[a] = d;
      chk(dev.mem[a], d);
    end
    // idle gap, then ready one cycle later as it is registered
    gap_seen = 0;
    while (req_ready !== 1'b1) begin
      @(negedge mclk);
      gap_seen++;
    end
    chk(gap_seen, `GAP_CYCLES + 1);
  endtask : xfer
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict;
    end
  end
  // edge addresses first, then random; overwrite then read back
  initial begin
    void'($urandom(43501));
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1fff : 13'($urandom);
      d = 8'($urandom);
      xfer(1'b0);
      d = ~d;
      xfer(1'b0);
      xfer(1'b1);
    end
    print_verdict;
  end
endmodule : tb_spi_cfg_master
